// file: pkg/mixer_pkg.sv
// Constants, field layouts and translation tables for the mixer register file.
`default_nettype none
package mixer_pkg;
    // ----------------------------------------------------------------
    // Host port offsets from legacy_port_base and the mixer index space
    // ----------------------------------------------------------------
    localparam logic [3:0] PORT_ADDR = 4'h4;
    localparam logic [3:0] PORT_DATA = 4'h5;
    localparam int NUM_REGS = 128;
    localparam logic [7:0] LAST_INDEX = 8'h7F;

    // ----------------------------------------------------------------
    // Mixer indices
    // ----------------------------------------------------------------
    localparam logic [6:0] IDX_RESET = 7'h00;
    localparam logic [6:0] IDX_LEG_AUDIO1 = 7'h04;
    localparam logic [6:0] IDX_LEG_MIC = 7'h0A;
    localparam logic [6:0] IDX_LEG_RECSRC = 7'h0C;
    localparam logic [6:0] IDX_MIC_PAN = 7'h1A;
    localparam logic [6:0] IDX_EXT_RECSRC = 7'h1C;
    localparam logic [6:0] IDX_LEG_MASTER = 7'h22;
    localparam logic [6:0] IDX_LEG_MUSIC = 7'h26;
    localparam logic [6:0] IDX_LEG_AUXA = 7'h28;
    localparam logic [6:0] IDX_LEG_LINE = 7'h2E;
    localparam logic [6:0] IDX_EXT_MASTER = 7'h32;
    localparam logic [6:0] IDX_MASTER_L = 7'h60;
    localparam logic [6:0] IDX_MASTER_R = 7'h62;
    localparam logic [6:0] IDX_EMU_CTRL = 7'h64;
    localparam logic [6:0] IDX_AUDIO2_CTRL = 7'h7A;
    localparam logic [6:0] EXT_ALIAS_BIT = 7'h10;

    // ----------------------------------------------------------------
    // Field positions and fixed values
    // ----------------------------------------------------------------
    localparam logic [7:0] LEG_STUCK_MASK = 8'h11;
    localparam int EMU_OFF_BIT = 0;
    localparam int MIXSEL_LSB = 3;
    localparam int MASTER_MUTE_BIT = 6;
    localparam logic [5:0] MASTER_DEFAULT = 6'd54;
    localparam logic [5:0] MASTER_MUTE_VOL = 6'd24;
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;

    // ----------------------------------------------------------------
    // Volume emulation tables: upper band edges and write targets
    // ----------------------------------------------------------------
    localparam logic [5:0] READ_EDGE [1:15] = '{6'd24, 6'd30, 6'd34, 6'd38, 6'd42,
        6'd46, 6'd50, 6'd54, 6'd55, 6'd57, 6'd58, 6'd60, 6'd61, 6'd62, 6'd63};
    localparam logic [5:0] WRITE_VOL [0:15] = '{6'd24, 6'd24, 6'd30, 6'd34, 6'd38,
        6'd42, 6'd46, 6'd50, 6'd54, 6'd55, 6'd56, 6'd58, 6'd59, 6'd61, 6'd62, 6'd63};

    // ----------------------------------------------------------------
    // Mixer source volume registers; the first source has no record control
    // ----------------------------------------------------------------
    localparam int NUM_SRC = 8;
    localparam logic [6:0] PLAY_IDX [0:7] = '{7'h14, 7'h7C, 7'h1A, 7'h36, 7'h38,
        7'h3A, 7'h3E, 7'h6D};
    localparam logic [6:0] REC_IDX [0:7] = '{7'h00, 7'h69, 7'h68, 7'h6B, 7'h6A,
        7'h6C, 7'h6E, 7'h6F};
    localparam logic [7:0] REC_PRESENT = 8'hFE;

    // ----------------------------------------------------------------
    // Volume law: attenuation from full scale in 1.5 dB units
    // ----------------------------------------------------------------
    localparam logic [3:0] KNEE_CODE = 4'd8;
    localparam logic [3:0] MAX_CODE = 4'd15;
    localparam logic [4:0] KNEE_ATTEN = 5'd7;

    // ----------------------------------------------------------------
    // Record source selection
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_MIC,
        SRC_CD,
        SRC_LINE,
        SRC_PLAY_MIX,
        SRC_REC_MIX
    } rec_src_t;
endpackage
`default_nettype wire

// file: core/mixer_regs.sv
// Mixer register file reached through the legacy address and data I/O ports.
//
// Operation
// - Write index to address port, then value to data port, to update a register.
// - Write index to address port, then read data port to fetch register.
// - Software reset keeps mixer registers; any write to index 00h resets them, except 60h and 62h with emulation off.
// - Legacy volume indices store bits 0 and 4 low, read them high.
// - Extended indices 14h,32h,36h,38h,3Eh share storage with legacy volume indices.
// - Write at 0Ah sets mic mix to 00h, 55h, AAh or FFh.
// - Read at 0Ah returns mic bits 3 and 2 on bits 2 and 1, bit 0 high.
// - Index 1Ah holds mic pan: left level high nibble, right level low nibble.
// - Legacy record source 0Ch: mic, CD or line; bit 0 cleared, reads one.
// - Extended record source 1Ch selects mic, CD, line, or a mixer via 7Ah.
// - Master emulation on after reset, off by 64h bit 0; drives master counters.
// - Reads at 32h convert 6-bit master to 4 bits; 22h also forces bits 0 and 4.
// - Emulated 4-bit master write sets both channels from fixed table, 0 mutes.
// - Mixer reset with emulation active sets both master counters to 54.
// - Playback mixer eight sources, record mixer seven, 4-bit left and right each.
// - Code 0 mutes, 15 is max; 3 dB steps to 8, 1.5 dB after.
// - Software reset disconnects first channel playback input; enable-speaker reconnects.
`default_nettype none
module mixer_regs (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Host I/O strobes, offset from legacy_port_base
    input wire logic [3:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    // Controller events
    input wire logic soft_rst_in,
    input wire logic spk_on_in,
    input wire logic spk_off_in,
    // Master volume
    output logic [5:0] master_vol_l_out,
    output logic [5:0] master_vol_r_out,
    output logic master_mute_l_out,
    output logic master_mute_r_out,
    output logic emu_on_out,
    // Record source and first channel playback gate
    output mixer_pkg::rec_src_t rec_src_out,
    output logic audio1_play_en_out,
    // Mixer gains: entry 2*source is left, 2*source+1 is right
    output logic [15:0][4:0] play_atten_out,
    output logic [15:0] play_mute_out,
    output logic [15:0][4:0] rec_atten_out,
    output logic [15:0] rec_mute_out
);

    // ----------------------------------------------------------------
    // Storage and decoded strobes
    // ----------------------------------------------------------------
    logic [7:0] regs_q [0:mixer_pkg::NUM_REGS-1];
    logic [7:0] index_q;
    logic [7:0] rdata_q;
    logic spk_en_q;
    logic [7:0] rd_val;
    logic [6:0] idx;
    logic idx_ok;
    logic wr_addr;
    logic wr_data;
    logic rd_data;
    logic emu_on;
    logic [3:0] master_nib;
    logic [5:0] master_new;

    assign idx = index_q[6:0];
    assign idx_ok = (index_q <= mixer_pkg::LAST_INDEX);
    assign wr_addr = io_wr_in && (io_addr_in == mixer_pkg::PORT_ADDR);
    assign wr_data = io_wr_in && (io_addr_in == mixer_pkg::PORT_DATA);
    assign rd_data = io_rd_in && (io_addr_in == mixer_pkg::PORT_DATA);
    assign emu_on = ~regs_q[mixer_pkg::IDX_EMU_CTRL][mixer_pkg::EMU_OFF_BIT];

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Legacy volume indices that alias an extended 8-bit register.
    function automatic logic is_leg_vol(input logic [6:0] i);
        is_leg_vol = (i == mixer_pkg::IDX_LEG_AUDIO1) || (i == mixer_pkg::IDX_LEG_MUSIC) ||
                     (i == mixer_pkg::IDX_LEG_AUXA) || (i == mixer_pkg::IDX_LEG_LINE);
    endfunction

    // Legacy index 0xh/2xh maps to extended 1xh/3xh by setting bit 4.
    function automatic logic [6:0] ext_of(input logic [6:0] i);
        ext_of = i | mixer_pkg::EXT_ALIAS_BIT;
    endfunction

    // Six-bit master volume to four-bit legacy code, by band edges.
    function automatic logic [3:0] to_nibble(input logic [7:0] r);
        logic [3:0] n;
        n = 4'd15;
        for (int k = 15; k >= 1; k--) begin
            if (r[5:0] <= mixer_pkg::READ_EDGE[k]) begin
                n = 4'(k);
            end
        end
        if (r[mixer_pkg::MASTER_MUTE_BIT]) begin
            n = 4'd0;
        end
        to_nibble = n;
    endfunction

    // Volume law: 1.5 dB units below code 15, two units per step under the knee.
    function automatic logic [4:0] atten_of(input logic [3:0] c);
        if (c >= mixer_pkg::KNEE_CODE) begin
            atten_of = 5'(mixer_pkg::MAX_CODE - c);
        end else begin
            atten_of = mixer_pkg::KNEE_ATTEN + 5'({mixer_pkg::KNEE_CODE - c, 1'b0});
        end
    endfunction

    // ----------------------------------------------------------------
    // Address port
    // ----------------------------------------------------------------

    // The index is never cleared by software reset, so a driver that re-selects
    // only on change keeps working across a controller reset.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            index_q <= 8'h00;
        end else if (wr_addr) begin
            index_q <= io_wdata_in;
        end
    end

    // ----------------------------------------------------------------
    // Emulated master write value
    // ----------------------------------------------------------------

    // The legacy port uses the left field only; its bit 4 is stored low.
    always_comb begin
        if (idx == mixer_pkg::IDX_LEG_MASTER) begin
            master_nib = {io_wdata_in[7:5], 1'b0};
        end else begin
            master_nib = io_wdata_in[7:4];
        end
        master_new = mixer_pkg::WRITE_VOL[master_nib];
    end

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------

    // Every write lands in one backing array; aliases fold onto the extended slot
    // so both views can never disagree.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < mixer_pkg::NUM_REGS; i++) begin
                regs_q[i] <= mixer_pkg::REG_RESET_VALUE;
            end
            regs_q[mixer_pkg::IDX_MASTER_L] <= {2'b00, mixer_pkg::MASTER_DEFAULT};
            regs_q[mixer_pkg::IDX_MASTER_R] <= {2'b00, mixer_pkg::MASTER_DEFAULT};
        end else if (wr_data && idx_ok) begin
            if (idx == mixer_pkg::IDX_RESET) begin
                for (int i = 0; i < mixer_pkg::NUM_REGS; i++) begin
                    regs_q[i] <= mixer_pkg::REG_RESET_VALUE;
                end
                if (emu_on) begin
                    regs_q[mixer_pkg::IDX_MASTER_L] <= {2'b00, mixer_pkg::MASTER_DEFAULT};
                    regs_q[mixer_pkg::IDX_MASTER_R] <= {2'b00, mixer_pkg::MASTER_DEFAULT};
                end else begin
                    regs_q[mixer_pkg::IDX_MASTER_L] <= regs_q[mixer_pkg::IDX_MASTER_L];
                    regs_q[mixer_pkg::IDX_MASTER_R] <= regs_q[mixer_pkg::IDX_MASTER_R];
                end
            end else if (is_leg_vol(idx)) begin
                regs_q[ext_of(idx)] <= io_wdata_in & ~mixer_pkg::LEG_STUCK_MASK;
            end else if (idx == mixer_pkg::IDX_LEG_MASTER || idx == mixer_pkg::IDX_EXT_MASTER) begin
                // With emulation off only direct writes at 60h and 62h change the counters.
                if (emu_on) begin
                    regs_q[mixer_pkg::IDX_MASTER_L] <= {1'b0, master_nib == 4'd0, master_new};
                    regs_q[mixer_pkg::IDX_MASTER_R] <= {1'b0, master_nib == 4'd0, master_new};
                end
            end else if (idx == mixer_pkg::IDX_LEG_MIC) begin
                regs_q[mixer_pkg::IDX_MIC_PAN] <= {4{io_wdata_in[2:1]}};
            end else if (idx == mixer_pkg::IDX_LEG_RECSRC) begin
                regs_q[mixer_pkg::IDX_EXT_RECSRC][2:0] <= {io_wdata_in[2:1], 1'b0};
            end else begin
                regs_q[idx] <= io_wdata_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Fixed bits of the legacy views read as one; their other unused bits read as zero.
    always_comb begin
        rd_val = 8'h00;
        if (!idx_ok || idx == mixer_pkg::IDX_RESET) begin
            rd_val = 8'h00;
        end else if (is_leg_vol(idx)) begin
            rd_val = regs_q[ext_of(idx)] | mixer_pkg::LEG_STUCK_MASK;
        end else if (idx == mixer_pkg::IDX_EXT_MASTER) begin
            rd_val = {to_nibble(regs_q[mixer_pkg::IDX_MASTER_L]),
                      to_nibble(regs_q[mixer_pkg::IDX_MASTER_R])};
        end else if (idx == mixer_pkg::IDX_LEG_MASTER) begin
            rd_val = {to_nibble(regs_q[mixer_pkg::IDX_MASTER_L]),
                      to_nibble(regs_q[mixer_pkg::IDX_MASTER_R])}
                     | mixer_pkg::LEG_STUCK_MASK;
        end else if (idx == mixer_pkg::IDX_LEG_MIC) begin
            rd_val = {5'b00000, regs_q[mixer_pkg::IDX_MIC_PAN][3:2], 1'b1};
        end else if (idx == mixer_pkg::IDX_LEG_RECSRC) begin
            rd_val = {5'b00000, regs_q[mixer_pkg::IDX_EXT_RECSRC][2:1], 1'b1};
        end else begin
            rd_val = regs_q[idx];
        end
    end

    // Read data is captured on the strobe and held until the next read.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_q <= 8'h00;
        end else if (io_rd_in && io_addr_in == mixer_pkg::PORT_ADDR) begin
            rdata_q <= index_q;
        end else if (rd_data) begin
            rdata_q <= rd_val;
        end
    end

    assign io_rdata_out = rdata_q;

    // ----------------------------------------------------------------
    // First channel playback gate
    // ----------------------------------------------------------------

    // Starts disconnected so power-up and setup pops stay out of the mix.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            spk_en_q <= 1'b0;
        end else if (spk_on_in) begin
            spk_en_q <= 1'b1;
        end else if (soft_rst_in || spk_off_in) begin
            spk_en_q <= 1'b0;
        end
    end

    assign audio1_play_en_out = spk_en_q;

    // ----------------------------------------------------------------
    // Record source decode
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] sel;
        sel = regs_q[mixer_pkg::IDX_EXT_RECSRC][2:0];
        if (!sel[1]) begin
            rec_src_out = mixer_pkg::SRC_MIC;
        end else if (!sel[2]) begin
            rec_src_out = mixer_pkg::SRC_CD;
        end else if (!sel[0]) begin
            rec_src_out = mixer_pkg::SRC_LINE;
        end else if (regs_q[mixer_pkg::IDX_AUDIO2_CTRL][mixer_pkg::MIXSEL_LSB +: 2] == 2'b00) begin
            rec_src_out = mixer_pkg::SRC_PLAY_MIX;
        end else begin
            rec_src_out = mixer_pkg::SRC_REC_MIX;
        end
    end

    // ----------------------------------------------------------------
    // Master volume outputs
    // ----------------------------------------------------------------
    assign master_vol_l_out = regs_q[mixer_pkg::IDX_MASTER_L][5:0];
    assign master_vol_r_out = regs_q[mixer_pkg::IDX_MASTER_R][5:0];
    assign master_mute_l_out = regs_q[mixer_pkg::IDX_MASTER_L][mixer_pkg::MASTER_MUTE_BIT];
    assign master_mute_r_out = regs_q[mixer_pkg::IDX_MASTER_R][mixer_pkg::MASTER_MUTE_BIT];
    assign emu_on_out = emu_on;

    // ----------------------------------------------------------------
    // Mixer gain per source and channel
    // ----------------------------------------------------------------

    // The first playback source is forced to mute while the speaker gate is off,
    // which keeps its stored level intact for when it is reconnected.
    for (genvar s = 0; s < mixer_pkg::NUM_SRC; s++) begin : g_src
        logic [7:0] pv;
        logic [7:0] rv;
        assign pv = (s == 0 && !spk_en_q) ? 8'h00 : regs_q[mixer_pkg::PLAY_IDX[s]];
        assign rv = mixer_pkg::REC_PRESENT[s] ? regs_q[mixer_pkg::REC_IDX[s]] : 8'h00;
        assign play_atten_out[2*s] = atten_of(pv[7:4]);
        assign play_atten_out[2*s+1] = atten_of(pv[3:0]);
        assign play_mute_out[2*s] = (pv[7:4] == 4'd0);
        assign play_mute_out[2*s+1] = (pv[3:0] == 4'd0);
        assign rec_atten_out[2*s] = atten_of(rv[7:4]);
        assign rec_atten_out[2*s+1] = atten_of(rv[3:0]);
        assign rec_mute_out[2*s] = (rv[7:4] == 4'd0);
        assign rec_mute_out[2*s+1] = (rv[3:0] == 4'd0);
    end

endmodule
`default_nettype wire

// file: tb/mixer_regs_properties.sv
// Concurrent checks on the ports of the mixer register file.
`default_nettype none
module mixer_regs_properties (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Host port
    input wire logic [3:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic [7:0] io_rdata_out,
    // Events and results
    input wire logic soft_rst_in,
    input wire logic spk_on_in,
    input wire logic [5:0] master_vol_l_out,
    input wire logic [5:0] master_vol_r_out,
    input wire logic master_mute_l_out,
    input wire logic master_mute_r_out,
    input wire logic emu_on_out,
    input wire logic audio1_play_en_out,
    input wire logic [15:0] play_mute_out
);
    logic [7:0] idx_q;

    // Mirror of the selected index, so that data-port accesses can be decoded here.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            idx_q <= 8'h00;
        end else if (io_wr_in && io_addr_in == 4'h4) begin
            idx_q <= io_wdata_in;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // A data-port write or read aimed at one index.
    sequence s_data_wr(logic [7:0] ix);
        io_wr_in && io_addr_in == 4'h5 && idx_q == ix;
    endsequence
    sequence s_data_rd(logic [7:0] ix);
        io_rd_in && io_addr_in == 4'h5 && idx_q == ix;
    endsequence

    index_echo_a: assert property (
        io_rd_in && io_addr_in == 4'h4 |=> io_rdata_out == $past(idx_q))
        else $error("Address port readback differs from the index.");
    emu_write_a: assert property (
        s_data_wr(8'h32) ##0 emu_on_out |=> master_vol_l_out == master_vol_r_out
        && master_mute_l_out == !$past(|io_wdata_in[7:4]) && master_mute_r_out == master_mute_l_out)
        else $error("Emulated master write set the channels wrongly.");
    emu_off_a: assert property (
        s_data_wr(8'h32) ##0 !emu_on_out |=> $stable(master_vol_l_out) && $stable(master_mute_r_out))
        else $error("Master changed while emulation was off.");
    mix_reset_a: assert property (
        s_data_wr(8'h00) ##0 emu_on_out |=> master_vol_l_out == 6'h36 && master_vol_r_out == 6'h36)
        else $error("Mixer reset did not restore the master default.");
    emu_ctrl_a: assert property (
        s_data_wr(8'h64) |=> emu_on_out == !$past(io_wdata_in[0]))
        else $error("Emulation enable does not follow its control bit.");
    soft_keep_a: assert property (
        soft_rst_in && !io_wr_in |=> $stable(master_vol_l_out) && $stable(master_vol_r_out))
        else $error("Software reset touched a mixer register.");
    mic_read_a: assert property (
        s_data_rd(8'h0A) |=> io_rdata_out[0] && io_rdata_out[7:3] == 5'h00)
        else $error("Legacy microphone read has a wrong fixed bit.");
    spk_on_a: assert property (
        spk_on_in |=> audio1_play_en_out && !play_mute_out[0] [*1])
        else $error("Enable-speaker event did not open the gate.");
    spk_gate_a: assert property (
        soft_rst_in && !spk_on_in |=> !audio1_play_en_out && play_mute_out[0])
        else $error("Software reset left the first channel connected.");
endmodule
`default_nettype wire

// file: tb/host_model.sv
// Host processor model issuing mixer port writes and reads.
`default_nettype none
module host_model (
    // Clock
    input wire logic clk_in,
    // Host I/O strobes
    output logic [3:0] io_addr_out,
    output logic io_wr_out,
    output logic io_rd_out,
    output logic [7:0] io_wdata_out,
    input wire logic [7:0] io_rdata_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet bus at time zero.
    initial begin
        io_addr_out = 4'h0;
        io_wr_out = 1'b0;
        io_rd_out = 1'b0;
        io_wdata_out = 8'h00;
    end

    // One strobe cycle; released lines show the inverse so stale data never looks valid.
    task automatic port_op(input logic wr, input logic [3:0] port, input logic [7:0] val);
        @(negedge clk_in);
        io_addr_out = port;
        io_wdata_out = val;
        io_wr_out = wr;
        io_rd_out = !wr;
        @(negedge clk_in);
        io_wr_out = 1'b0;
        io_rd_out = 1'b0;
        io_addr_out = ~port;
        io_wdata_out = ~val;
    endtask

    // Index first, then data, as every mixer access needs.
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
        port_op(1'b1, 4'h4, idx);
        port_op(1'b1, 4'h5, val);
    endtask
    task automatic reg_rd(input logic [7:0] idx, output logic [7:0] val);
        port_op(1'b1, 4'h4, idx);
        port_op(1'b0, 4'h5, 8'h00);
        val = io_rdata_in;
    endtask
endmodule
`default_nettype wire

// file: tb/audio_mixer_register_access_test.sv
// Self-checking bench for the mixer register file.
`default_nettype none
module audio_mixer_register_access_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic soft_rst_in = 1'b0;
    logic spk_on_in = 1'b0;
    logic spk_off_in = 1'b0;
    logic [3:0] io_addr_in;
    logic io_wr_in, io_rd_in, emu_on_out, audio1_play_en_out;
    logic [7:0] io_wdata_in, io_rdata_out;
    logic [5:0] master_vol_l_out, master_vol_r_out;
    logic master_mute_l_out, master_mute_r_out;
    mixer_pkg::rec_src_t rec_src_out;
    logic [15:0][4:0] play_atten_out, rec_atten_out;
    logic [15:0] play_mute_out, rec_mute_out;
    int bad_count = 0;
    int checks_done = 0;
    // Master volume reached by each emulated write code.
    localparam logic [5:0] VOL_OF [16] = '{6'h18, 6'h18, 6'h1E, 6'h22, 6'h26, 6'h2A, 6'h2E,
        6'h32, 6'h36, 6'h37, 6'h38, 6'h3A, 6'h3B, 6'h3D, 6'h3E, 6'h3F};

    // Free-running 10 MHz clock.
    always #50 clk_in = ~clk_in;

    mixer_regs u_mixer_regs (.clk_in, .sys_rst_in, .io_addr_in, .io_wr_in, .io_rd_in,
        .io_wdata_in, .io_rdata_out, .soft_rst_in, .spk_on_in, .spk_off_in, .master_vol_l_out,
        .master_vol_r_out, .master_mute_l_out, .master_mute_r_out, .emu_on_out, .rec_src_out,
        .audio1_play_en_out, .play_atten_out, .play_mute_out, .rec_atten_out, .rec_mute_out);
    host_model u_host_model (.clk_in, .io_addr_out(io_addr_in), .io_wr_out(io_wr_in),
        .io_rd_out(io_rd_in), .io_wdata_out(io_wdata_in), .io_rdata_in(io_rdata_out));

    // Shared comparison, plus helpers for register traffic and event pulses.
    task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] got;
        u_host_model.reg_rd(idx, got);
        chk_val($sformatf("reg %h", idx), exp, got);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        u_host_model.reg_wr(idx, val);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_in) s = 1'b1;
        @(negedge clk_in) s = 1'b0;
    endtask
    // Attenuation below full scale in 1.5 dB units: 3 dB steps under code 8.
    function automatic logic [7:0] exp_att(input int c);
        return (c >= 8) ? 8'(15 - c) : 8'(23 - 2 * c);
    endfunction

    task automatic t_reset;
        chk_val("vol_l", 8'h36, {2'b00, master_vol_l_out});
        chk_val("emu", 8'h01, {7'h00, emu_on_out});
        chk_reg(8'h1A, 8'h00);
        wr(8'h90, 8'h5A);
        chk_reg(8'h90, 8'h00);
    endtask
    task automatic t_alias;
        logic [7:0] leg [4] = '{8'h04, 8'h26, 8'h28, 8'h2E};
        for (int i = 0; i < 4; i++) begin
            wr(leg[i], 8'h00);
            chk_reg(leg[i], 8'h11);
            wr(leg[i] | 8'h10, 8'hFF);
            chk_reg(leg[i], 8'hFF);
            wr(leg[i], 8'hFF);
            chk_reg(leg[i] | 8'h10, 8'hEE);
        end
    endtask
    task automatic t_vol_law;
        for (int c = 0; c < 16; c++) begin
            wr(8'h36, {c[3:0], 4'hF});
            wr(8'h69, {4'hF, c[3:0]});
            chk_val("play_mute", {7'h00, c == 0}, {7'h00, play_mute_out[6]});
            chk_val("rec_mute", {7'h00, c == 0}, {7'h00, rec_mute_out[3]});
            chk_val("play_right", 8'h00, {3'h0, play_atten_out[7]});
            if (c != 0) begin
                chk_val("play_atten", exp_att(c), {3'h0, play_atten_out[6]});
                chk_val("rec_atten", exp_att(c), {3'h0, rec_atten_out[3]});
            end
        end
    endtask
    task automatic t_mic;
        logic [7:0] mic [4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};
        for (int d = 0; d < 4; d++) begin
            wr(8'h0A, {5'h00, d[1:0], 1'b1});
            chk_reg(8'h1A, mic[d]);
            chk_reg(8'h0A, {5'h00, mic[d][3:2], 1'b1});
        end
        wr(8'h1A, 8'h5C);
        chk_val("mic_left", 8'h0D, {3'h0, play_atten_out[4]});
        chk_val("mic_right", 8'h03, {3'h0, play_atten_out[5]});
    endtask
    task automatic t_recsrc;
        logic [7:0] mx [5] = '{8'h00, 8'h08, 8'h18, 8'h10, 8'h08};
        logic [7:0] sel [5] = '{8'h07, 8'h07, 8'h06, 8'h03, 8'h05};
        logic [7:0] ex [5] = '{8'h03, 8'h04, 8'h02, 8'h01, 8'h00};
        logic [7:0] leg [4] = '{8'h00, 8'h01, 8'h00, 8'h02};
        for (int d = 0; d < 4; d++) begin
            wr(8'h0C, {5'h1F, d[1:0], 1'b1});
            chk_val("rec_src", leg[d], 8'(rec_src_out));
            chk_reg(8'h0C, {5'h00, d[1:0], 1'b1});
        end
        for (int i = 0; i < 5; i++) begin
            wr(8'h7A, mx[i]);
            wr(8'h1C, sel[i]);
            chk_val("rec_src", ex[i], 8'(rec_src_out));
        end
    endtask
    task automatic t_master;
        for (int v = 0; v < 16; v++) begin
            wr(8'h32, {v[3:0], 4'h0});
            chk_val("vol_r", {2'b00, VOL_OF[v]}, {2'b00, master_vol_r_out});
            chk_val("mute", {7'h00, v == 0}, {7'h00, master_mute_l_out});
            chk_reg(8'h32, {v[3:0], v[3:0]});
            chk_reg(8'h22, {v[3:0], v[3:0]} | 8'h11);
        end
        wr(8'h60, 8'h19);
        chk_reg(8'h32, 8'h2F);
        wr(8'h22, 8'hE0);
        chk_val("vol_l", 8'h3E, {2'b00, master_vol_l_out});
        wr(8'h64, 8'h01);
        wr(8'h32, 8'h10);
        chk_reg(8'h62, 8'h3E);
        wr(8'h00, 8'h00);
        chk_reg(8'h60, 8'h3E);
        chk_reg(8'h1A, 8'h00);
        wr(8'h00, 8'hA5);
        chk_val("vol_l", 8'h36, {2'b00, master_vol_l_out});
    endtask
    task automatic t_events;
        wr(8'h14, 8'h33);
        pulse(spk_on_in);
        chk_val("gate", 8'h01, {7'h00, audio1_play_en_out});
        pulse(soft_rst_in);
        chk_reg(8'h14, 8'h33);
        chk_val("mute0", 8'h01, {7'h00, play_mute_out[0]});
        pulse(spk_on_in);
        pulse(spk_off_in);
        chk_val("gate", 8'h00, {7'h00, audio1_play_en_out});
        u_host_model.port_op(1'b1, 4'h5, 8'h42);
        u_host_model.port_op(1'b0, 4'h5, 8'h00);
        chk_val("hold", 8'h42, io_rdata_out);
        u_host_model.port_op(1'b0, 4'h4, 8'h00);
        chk_val("index", 8'h14, io_rdata_out);
    endtask

    // Verdict in one place; the watchdog lands here too.
    task automatic wrap_up;
        if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Main sequence: 12 cycles of reset, then the scenarios in turn.
    initial begin
        repeat (12) @(posedge clk_in);
        @(negedge clk_in) sys_rst_in = 1'b0;
        t_reset();
        t_alias();
        t_vol_law();
        t_mic();
        t_recsrc();
        t_master();
        t_events();
        wrap_up();
    end
    // The scenarios need under 2000 cycles, so 20000 means a hang.
    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        wrap_up();
    end
endmodule
bind mixer_regs mixer_regs_properties u_mixer_regs_properties (.clk_in, .sys_rst_in,
    .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in, .io_rdata_out, .soft_rst_in, .spk_on_in,
    .master_vol_l_out, .master_vol_r_out, .master_mute_l_out, .master_mute_r_out, .emu_on_out,
    .audio1_play_en_out, .play_mute_out);
`default_nettype wire
